// ---- phy_management_register_bank.sv ----
/*
  Top of the PHY management register bank: control register, interrupt
  status/mask/clear, self-test and expansion registers, AHB-Lite access.
  Assumes straps are steady around reset release and that the datapath
  and negotiation engine report through the plain event inputs.
*/
// Functional notes
// [RULE1] Writing reset bit restores control defaults
// [RULE2] Reset bit reads one until done
// [RULE3] Loopback routes transmit back to receive
// [RULE4] Loopback turns around at converter
// [RULE5] Two speed bits select forced speed
// [RULE6] Low speed default comes from strap; code loads zero instead when strap_autoneg is high
// [RULE7] Negotiation enabled ignores speed and duplex
// [RULE8] Negotiation off lets bits set mode
// [RULE9] Negotiation enable default comes from strap
// [RULE10] Latched-high bit holds one until read
// [RULE11] Latched-low bit holds zero until read
// [RULE12] Self-clearing bit drops when event ends
// [RULE13] Permanent bits ignore writes
// [RULE14] Strap bits sample pin at reset
// [RULE15] Interrupt clear bits self-clear
// [RULE16] Duplex bit selects full or half
// [RULE17] Renegotiate bit clears once restarted
// [RULE18] Isolate ignores transmit, releases outputs
// [RULE19] Power-down leaves only management active
// [RULE20] Sixteen-bit registers; reserved writes ignored
`timescale 1ns/1ps
`include "phy_mgmt_consts.svh"
module phy_management_register_bank
  import phy_mgmt_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic strap_autoneg,
  input wire logic strap_speed_lo,
  input wire logic strap_duplex,
  input wire logic [15:0] int_events,
  input wire logic link_up,
  input wire logic an_restarted,
  input wire logic mgmt_fault,
  input wire logic [7:0] tx_data,
  input wire logic tx_en,
  input wire logic [7:0] conv_rx_data,
  input wire logic conv_rx_dv,
  output logic [7:0] conv_tx_data,
  output logic conv_tx_en,
  output logic [7:0] rx_data,
  output logic rx_dv,
  output logic rx_oe,
  output logic autoneg_enable_bit,
  output logic renegotiate_bit,
  output logic [1:0] link_speed,
  output logic full_duplex,
  output logic power_down,
  output logic col_test
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  reg_access_if acc ();
  logic [31:0] slave_rdata; // Slave read word
  logic slave_ready; // Slave ready

  ahb_reg_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(slave_ready),
    .hrdata(slave_rdata),
    .acc(acc)
  );

  // Slave outputs already come from its flip-flops
  assign hreadyout = slave_ready;
  assign hrdata = slave_rdata;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [15:0] control; // Control register
  logic [15:0] int_status; // Latched-high event bits
  logic [15:0] int_mask; // Interrupt mask
  logic [15:0] int_clear; // Self-clearing clear strobes
  logic [15:0] exp_ctl; // Expansion access control
  logic [15:0] test_cnt; // Self-test counter
  logic [15:0] test_cfg; // Self-test config
  logic [15:0] exp_addr; // Expansion address pointer
  logic [15:0] support; // Support register
  logic link_latched; // Latched-low link status
  logic fault_latched; // Latched-high fault, cleared only by a link status read
  logic [2:0] straps; // Straps caught after reset release
  logic strap_done; // Straps have been caught
  logic [31:0] soft_cnt; // Software reset countdown
  logic [2:0] reneg_cnt; // All ones once strap defaults are loaded
  logic loop_en; // Transmit enable one stage late, for the loop

  // Register number decode used by read and write paths
  function automatic logic hit(input logic [4:0] n, input logic [4:0] r);
    hit = (n == r);
  endfunction

  wire wr_ctl = acc.wr && hit(acc.num, `REG_CONTROL);
  wire wr_mask = acc.wr && hit(acc.num, `REG_INT_MASK);
  wire wr_clr = acc.wr && hit(acc.num, `REG_INT_CLEAR);
  wire wr_expc = acc.wr && hit(acc.num, `REG_EXP_CTL);
  wire wr_cfg = acc.wr && hit(acc.num, `REG_TEST_CFG);
  wire wr_expa = acc.wr && hit(acc.num, `REG_EXP_ADDR);
  wire wr_sup = acc.wr && hit(acc.num, `REG_SUPPORT);
  wire rd_stat = acc.rd && hit(acc.num, `REG_INT_STATUS);
  wire rd_link = acc.rd && hit(acc.num, `REG_LINK_STATUS);
  wire soft_busy = control[`CTL_RESET];

  // Strap-derived control defaults
  wire [15:0] ctl_default = `CTL_RESET_VAL
    | ({15'h0000, straps[0]} << `CTL_AUTONEG_ENABLE_BIT) // RULE9
    | ({15'h0000, straps[0] ? 1'b0 : straps[1]} << `CTL_SPEED_LO) // RULE6
    | ({15'h0000, straps[0] ? 1'b0 : straps[2]} << `CTL_DUPLEX);

  // ----------------------------------------------------------------------
  // Strap capture: clocked, right after reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      straps <= 3'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      straps <= {strap_duplex, strap_speed_lo, strap_autoneg}; // RULE14
      strap_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Soft reset holds the register at defaults and bit 15 high for the
  // full countdown; writes meanwhile are dropped so defaults stick.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control <= `CTL_RESET_VAL;
      soft_cnt <= 32'h0000_0000;
    end else if (!strap_done) begin
      control <= `CTL_RESET_VAL;
    end else if (reneg_cnt != 3'h7) begin
      // Load once only, so a later write of zero is not overridden
      control <= ctl_default; // RULE6 RULE9
    end else if (soft_busy) begin
      if (soft_cnt <= 32'h0000_0001) begin
        control <= ctl_default; // RULE2
        soft_cnt <= 32'h0000_0000;
      end else begin
        soft_cnt <= soft_cnt - 32'h0000_0001;
      end
    end else if (wr_ctl && acc.wdata[`CTL_RESET]) begin
      control <= ctl_default | 16'h8000; // RULE1
      soft_cnt <= SOFT_RESET_CYCLES;
    end else if (wr_ctl) begin
      control <= (acc.wdata & `CTL_RW_MASK) |
        (control & ~`CTL_RW_MASK); // RULE20
    end else if (control[`CTL_RENEG] &&
                 (an_restarted || !control[`CTL_AUTONEG_ENABLE_BIT])) begin
      control[`CTL_RENEG] <= 1'b0; // RULE17 RULE12
    end
  end

  // Straps default load after first capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reneg_cnt <= 3'h0;
    end else if (strap_done && reneg_cnt != 3'h7) begin
      reneg_cnt <= 3'h7;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and clear
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_int
      // Event wins over read and over clear
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          int_status[i] <= 1'b0;
        end else if (int_events[i]) begin
          int_status[i] <= 1'b1; // RULE10
        end else if (rd_stat || int_clear[i]) begin
          int_status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Clear bits live one cycle after the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_clear <= 16'h0000;
      int_mask <= `MASK_RESET_VAL;
    end else begin
      int_clear <= wr_clr ? acc.wdata : 16'h0000; // RULE15
      if (wr_mask) begin
        int_mask <= acc.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link latched-low, fault latched-high/cleared on link status read
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_latched <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      if (!link_up) begin
        link_latched <= 1'b0; // RULE11
      end else if (rd_link) begin
        link_latched <= 1'b1;
      end
      if (mgmt_fault) begin
        fault_latched <= 1'b1; // RULE10
      end else if (rd_link) begin
        fault_latched <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Vendor registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_ctl <= 16'h0000;
      test_cfg <= 16'h0000;
      exp_addr <= 16'h0000;
      support <= `SUPPORT_FIXED;
      test_cnt <= 16'h0000;
    end else begin
      if (wr_expc) begin
        exp_ctl <= acc.wdata;
      end
      if (wr_cfg) begin
        test_cfg <= acc.wdata;
      end
      if (wr_expa) begin
        exp_addr <= acc.wdata;
      end
      if (wr_sup) begin
        support <= (acc.wdata & `SUPPORT_RW_MASK) |
          (`SUPPORT_FIXED & ~`SUPPORT_RW_MASK); // RULE13
      end
      // Counts converter receive-valid cycles while self-test and loopback are both enabled
      if (test_cfg[0] && conv_rx_dv && control[`CTL_LOOPBACK]) begin
        test_cnt <= test_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [4:0] rn = acc.num;
  assign acc.rdata =
    hit(rn, `REG_CONTROL) ? control :
    hit(rn, `REG_INT_STATUS) ? (int_status & int_mask) | int_status :
    hit(rn, `REG_INT_MASK) ? int_mask :
    hit(rn, `REG_EXP_CTL) ? exp_ctl :
    hit(rn, `REG_INT_CLEAR) ? int_clear :
    hit(rn, `REG_TEST_CNT) ? test_cnt :
    hit(rn, `REG_TEST_CFG) ? test_cfg :
    hit(rn, `REG_EXP_ADDR) ? exp_addr :
    hit(rn, `REG_SUPPORT) ? support :
    hit(rn, `REG_LINK_STATUS) ?
      {14'h0000, fault_latched, link_latched} : 16'h0000;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire an_on = control[`CTL_AUTONEG_ENABLE_BIT];
  wire quiet = control[`CTL_ISOLATE] || control[`CTL_POWER_DOWN];
  // Forced speed only when negotiation is off
  wire [1:0] forced_speed =
    {control[`CTL_SPEED_HI], control[`CTL_SPEED_LO]}; // RULE5
  wire [1:0] next_speed = an_on ? spd_1000 : forced_speed; // RULE7 RULE8
  wire next_duplex = an_on ? 1'b1 : control[`CTL_DUPLEX]; // RULE16
  wire loop = control[`CTL_LOOPBACK];

  // ----------------------------------------------------------------------
  // Datapath steering and status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_tx_data <= 8'h00;
      conv_tx_en <= 1'b0;
      rx_data <= 8'h00;
      rx_dv <= 1'b0;
      rx_oe <= 1'b0;
      loop_en <= 1'b0;
    end else begin
      // Transmit ignored when isolated or powered down
      conv_tx_data <= quiet ? 8'h00 : tx_data; // RULE18 RULE19
      conv_tx_en <= !quiet && tx_en && !loop;
      // Enable takes the same two stages as the looped byte
      loop_en <= !quiet && tx_en;
      // Loop at the converter edge so the whole path is exercised
      rx_data <= loop ? conv_tx_data : conv_rx_data; // RULE3 RULE4
      rx_dv <= !quiet && (loop ? loop_en : conv_rx_dv);
      rx_oe <= !quiet; // RULE18
    end
  end

  // Registered mode outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
      autoneg_enable_bit <= 1'b0;
      renegotiate_bit <= 1'b0;
      link_speed <= 2'b00;
      full_duplex <= 1'b0;
      power_down <= 1'b0;
      col_test <= 1'b0;
    end else begin
      hresp <= 1'b0;
      autoneg_enable_bit <= an_on;
      renegotiate_bit <= an_on && control[`CTL_RENEG]; // RULE17
      link_speed <= next_speed;
      full_duplex <= next_duplex;
      power_down <= control[`CTL_POWER_DOWN]; // RULE19
      col_test <= control[`CTL_COL_TEST];
    end
  end

endmodule

// ---- phy_mgmt_consts.svh ----
/*
  Constants of the PHY management register bank: offsets, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef PHY_MGMT_CONSTS_SVH
`define PHY_MGMT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register numbers (byte address is four times the number)
// ----------------------------------------------------------------------
`define REG_CONTROL 5'h00
`define REG_INT_STATUS 5'h14
`define REG_INT_MASK 5'h15
`define REG_EXP_CTL 5'h16
`define REG_INT_CLEAR 5'h17
`define REG_TEST_CNT 5'h18
`define REG_TEST_CFG 5'h19
`define REG_EXP_ADDR 5'h1e
`define REG_SUPPORT 5'h1f
`define REG_LINK_STATUS 5'h11

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_RESET 15
`define CTL_LOOPBACK 14
`define CTL_SPEED_LO 13
`define CTL_AUTONEG_ENABLE_BIT 12
`define CTL_POWER_DOWN 11
`define CTL_ISOLATE 10
`define CTL_RENEG 9
`define CTL_DUPLEX 8
`define CTL_COL_TEST 7
`define CTL_SPEED_HI 6
`define CTL_RW_MASK 16'h7fc0

// ----------------------------------------------------------------------
// Reset values and permanent bits
// ----------------------------------------------------------------------
`define CTL_RESET_VAL 16'h0000
`define MASK_RESET_VAL 16'h0000
`define SUPPORT_FIXED 16'h0000
`define SUPPORT_RW_MASK 16'h00ff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SOFT_RESET_NS 1200000
`define CLK_PERIOD_NS 4
`define SOFT_RESET_CYCLES (`SOFT_RESET_NS / `CLK_PERIOD_NS)
`define RENEG_CYCLES 4

`endif

// ---- phy_mgmt_pkg.sv ----
/*
  Types of the PHY management register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package phy_mgmt_pkg;

  // Bus slave phase states, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_write = 3'b010,
    st_read = 3'b100
  } bus_state_t;

  // Resolved link speed
  typedef enum logic [1:0] {
    spd_10 = 2'b00,
    spd_100 = 2'b01,
    spd_1000 = 2'b10,
    spd_reserved = 2'b11
  } link_speed_t;

endpackage

// ---- reg_access_if.sv ----
/*
  Carrier between the bus slave and the register bank: one decoded
  register access per cycle.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface reg_access_if;
  logic wr; // One-cycle write strobe
  logic rd; // One-cycle read strobe
  logic [4:0] num; // Register number
  logic [15:0] wdata; // Write data
  logic [15:0] rdata; // Read data, valid with rd
  modport slave (output wr, rd, num, wdata, input rdata);
  modport bank (input wr, rd, num, wdata, output rdata);
endinterface

// ---- ahb_reg_slave.sv ----
/*
  AHB-Lite slave that turns single word transfers into register strobes.
  Assumes one master, word transfers only; response is always OKAY.
*/
`timescale 1ns/1ps
module ahb_reg_slave
  import phy_mgmt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  reg_access_if.slave acc
);

  bus_state_t state; // Current data-phase kind
  logic [4:0] num_q; // Captured register number

  // Address phase accepted on NONSEQ or SEQ
  wire take = hsel && hready && htrans[1];

  // ----------------------------------------------------------------------
  // Strobes: write lands in the data phase, read is asked in it too
  // ----------------------------------------------------------------------
  assign acc.wr = (state == st_write);
  assign acc.rd = (state == st_read);
  assign acc.num = num_q;
  assign acc.wdata = hwdata[15:0];

  // Phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= st_idle;
      num_q <= 5'h00;
    end else if (take) begin
      state <= hwrite ? st_write : st_read;
      num_q <= haddr[6:2];
    end else begin
      state <= st_idle;
    end
  end

  // Read data registered; ready drops one cycle for reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= !(take && !hwrite);
      if (state == st_read) begin
        hrdata <= {16'h0000, acc.rdata};
      end
    end
  end

endmodule

// ---- mac_partner.sv ----
/*
  MAC-side partner: sends a four-byte frame on request, keeps converter idle.
  Assumes one clock shared with the register bank; go lasts one cycle.
*/
`timescale 1ns/1ps
module mac_partner (
  input wire logic hclk,
  input wire logic go,
  output logic [7:0] tx_data,
  output logic tx_en,
  output logic [7:0] conv_rx_data,
  output logic conv_rx_dv
);
  logic [2:0] left = 3'h0; // Bytes still to send
  initial begin
    tx_data = 8'h00;
    tx_en = 1'b0;
    conv_rx_data = 8'h00;
    conv_rx_dv = 1'b0;
  end
  // ----------------------------------------------------------------
  // Frame source: bytes 8'h3c to 8'h3f
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (left != 3'h0) begin
      tx_en <= 1'b1;
      tx_data <= 8'h40 - {5'h00, left};
      left <= left - 3'h1;
    end else begin
      // Idle lines toggle so a stale byte can never pass for data
      tx_en <= 1'b0;
      tx_data <= ~tx_data;
    end
    if (go) begin
      left <= 3'h4;
    end
    // Converter never offers receive data here
    conv_rx_data <= ~conv_rx_data;
    conv_rx_dv <= 1'b0;
  end
endmodule

// ---- phy_management_register_bank_asserts.sv ----
/*
  Concurrent checks on the register bank top ports.
  Assumes one clock domain; attached by the bind below.
*/
`timescale 1ns/1ps
module phy_management_register_bank_checker
  import phy_mgmt_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = 20
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic an_restarted,
  input wire logic rx_dv,
  input wire logic conv_tx_en,
  input wire logic autoneg_enable_bit,
  input wire logic renegotiate_bit,
  input wire logic [1:0] link_speed,
  input wire logic full_duplex,
  input wire logic power_down
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  sequence s_read_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_write_taken;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence s_wait_then_ready;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait;
    s_read_taken |=> s_wait_then_ready;
  endproperty
  property p_write_nowait;
    s_write_taken |=> hreadyout;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_upper_zero;
    hreadyout |-> hrdata[31:16] == 16'h0000;
  endproperty
  // Read data only moves at the end of a read wait cycle
  property p_hrdata_stands;
    hreadyout && $past(hreadyout) |-> $stable(hrdata);
  endproperty
  // ----------------------------------------------------------------
  // Mode outputs; two cycles of slack for the registered outputs
  // ----------------------------------------------------------------
  property p_autoneg_mode;
    autoneg_enable_bit [*2] |-> link_speed == spd_1000 && full_duplex;
  endproperty
  property p_reneg_clears;
    renegotiate_bit && an_restarted |-> ##[1:2] !renegotiate_bit;
  endproperty
  property p_power_quiet;
    power_down [*2] |-> !rx_dv && !conv_tx_en;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read did not wait one cycle");
  a_write_nowait: assert property (p_write_nowait)
    else $error("write data phase stalled");
  a_okay: assert property (p_okay)
    else $error("response not okay");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read data not zero");
  a_hrdata_stands: assert property (p_hrdata_stands)
    else $error("read data moved outside a read");
  a_autoneg_mode: assert property (p_autoneg_mode)
    else $error("mode bits not ignored under negotiation");
  a_reneg_clears: assert property (p_reneg_clears)
    else $error("restart bit did not clear");
  a_power_quiet: assert property (p_power_quiet)
    else $error("datapath active in power-down");
endmodule

bind phy_management_register_bank phy_management_register_bank_checker
  #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) i_phy_management_register_bank_checker (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .hrdata, .an_restarted, .rx_dv, .conv_tx_en, .autoneg_enable_bit,
  .renegotiate_bit, .link_speed, .full_duplex, .power_down
);

// ---- tb_phy_management_register_bank.sv ----
/*
  Self-checking bench for the register bank over AHB-Lite.
  Assumes the checker is bound in and the MAC partner model is compiled.
*/
`timescale 1ns/1ps
module tb_phy_management_register_bank;
  import phy_mgmt_pkg::*;
  localparam int unsigned SR = 20; // Shortened soft reset
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, go;
  logic strap_autoneg, strap_speed_lo, strap_duplex;
  logic link_up, an_restarted, mgmt_fault, tx_en, conv_rx_dv;
  logic conv_tx_en, rx_dv, rx_oe, autoneg_enable_bit, renegotiate_bit;
  logic full_duplex, power_down, col_test;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, link_speed;
  logic [2:0] hsize;
  logic [15:0] int_events, q;
  logic [7:0] tx_data, conv_rx_data, conv_tx_data, rx_data;
  logic [7:0] rxq[$]; // Bytes seen on the receive side
  int n_errors = 0;
  int num_checks = 0;
  wire logic hready = hreadyout; // Single slave drives the bus ready
  always #2 hclk = ~hclk;
  phy_management_register_bank #(.SOFT_RESET_CYCLES(SR))
    i_phy_management_register_bank (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hsize, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .strap_autoneg, .strap_speed_lo,
    .strap_duplex, .int_events, .link_up, .an_restarted, .mgmt_fault,
    .tx_data, .tx_en, .conv_rx_data, .conv_rx_dv, .conv_tx_data,
    .conv_tx_en, .rx_data, .rx_dv, .rx_oe, .autoneg_enable_bit,
    .renegotiate_bit, .link_speed, .full_duplex, .power_down, .col_test
  );
  mac_partner i_mac_partner (.hclk, .go, .tx_data, .tx_en, .conv_rx_data,
    .conv_rx_dv);
  // Collect looped bytes
  always @(posedge hclk) begin
    if (rx_dv === 1'b1) begin
      rxq.push_back(rx_data);
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks; each is entered right after a rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic [4:0] n, input logic w,
                      input logic [15:0] d, output logic [15:0] r);
    hsel <= 1'b1;
    haddr <= {25'h0, n, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[15:0];
  endtask
  task automatic chk(input string name, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] n, input logic [15:0] d);
    logic [15:0] r;
    xfer(n, 1'b1, d, r);
  endtask
  task automatic rd_chk(input string name, input logic [4:0] n,
                        input logic [15:0] e);
    logic [15:0] r;
    xfer(n, 1'b0, 16'h0000, r);
    chk(name, e, r);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    $display("timeout");
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, go, an_restarted, mgmt_fault} = 6'h00;
    {haddr, hwdata, htrans, int_events} = '0;
    hsize = 3'b010;
    {strap_autoneg, strap_speed_lo, strap_duplex, link_up} = 4'b0111;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd_chk("control", 5'h00, 16'h2100);
    chk("speed", {14'h0, spd_100}, {14'h0, link_speed});
    chk("duplex", 16'h0001, {15'h0, full_duplex});
    $display("test straps done");
    for (int i = 0; i < 4; i++) begin
      wr(5'h00, {2'b00, i[0], 6'h00, i[1], 6'h00});
      repeat (2) @(posedge hclk);
      chk("speed", {14'h0, i[1:0]}, {14'h0, link_speed});
      chk("duplex", 16'h0000, {15'h0, full_duplex});
    end
    $display("test forced modes done");
    wr(5'h00, 16'h3040);
    repeat (2) @(posedge hclk);
    chk("speed", {14'h0, spd_1000}, {14'h0, link_speed});
    chk("duplex", 16'h0001, {15'h0, full_duplex});
    wr(5'h00, 16'h1200);
    rd_chk("restart", 5'h00, 16'h1200);
    an_restarted <= 1'b1;
    @(posedge hclk);
    an_restarted <= 1'b0;
    repeat (3) @(posedge hclk);
    rd_chk("restart", 5'h00, 16'h1000);
    $display("test negotiation done");
    wr(5'h00, 16'h0400);
    repeat (2) @(posedge hclk);
    chk("isolate", 16'h0000, {15'h0, rx_oe});
    wr(5'h00, 16'h0880);
    repeat (2) @(posedge hclk);
    chk("power", 16'h0001, {15'h0, power_down});
    chk("coltest", 16'h0001, {15'h0, col_test});
    wr(5'h00, 16'h4000);
    rxq.delete();
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (12) @(posedge hclk);
    chk("looped count", 16'h0004, 16'(rxq.size()));
    foreach (rxq[i]) chk("looped", {8'h0, 8'h3c + 8'(i)}, {8'h0, rxq[i]});
    $display("test datapath done");
    // A control write during the soft reset must be dropped
    wr(5'h00, 16'h8000);
    xfer(5'h00, 1'b0, 16'h0000, q);
    chk("reset bit", 16'h0001, {15'h0, q[15]});
    wr(5'h00, 16'h4000);
    repeat (SR + 10) @(posedge hclk);
    rd_chk("control", 5'h00, 16'h2100);
    $display("test soft reset done");
    xfer(5'h11, 1'b0, 16'h0000, q);
    link_up <= 1'b0;
    @(posedge hclk);
    link_up <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_chk("link", 5'h11, 16'h0000);
    rd_chk("link", 5'h11, 16'h0001);
    mgmt_fault <= 1'b1;
    @(posedge hclk);
    mgmt_fault <= 1'b0;
    repeat (2) @(posedge hclk);
    rd_chk("link", 5'h11, 16'h0003);
    rd_chk("link", 5'h11, 16'h0001);
    $display("test latched bits done");
    rd_chk("mask", 5'h15, 16'h0000);
    wr(5'h15, 16'ha5a5);
    rd_chk("mask", 5'h15, 16'ha5a5);
    xfer(5'h14, 1'b0, 16'h0000, q);
    int_events <= 16'h0008;
    @(posedge hclk);
    int_events <= 16'h0000;
    repeat (2) @(posedge hclk);
    rd_chk("status", 5'h14, 16'h0008);
    rd_chk("status", 5'h14, 16'h0000);
    int_events <= 16'h0020;
    @(posedge hclk);
    int_events <= 16'h0000;
    repeat (2) @(posedge hclk);
    wr(5'h17, 16'h0020);
    rd_chk("clear", 5'h17, 16'h0000);
    rd_chk("status", 5'h14, 16'h0000);
    $display("test interrupts done");
    wr(5'h1f, 16'hffff);
    rd_chk("support", 5'h1f, 16'h00ff);
    wr(5'h0c, 16'hffff);
    rd_chk("unmapped", 5'h0c, 16'h0000);
    $display("test fixed bits done");
    tally_and_finish();
  end
endmodule
